// file: rtl/phmp_host.sv
`timescale 1ns/1ns
module phmp_host #(
    parameter int PHASE_CYCLES = phmp_pkg::PHASE_CYC
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic IRQ_OUT,
    // pins to the device
    phmp_if.host PORT
);
    import phmp_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_FINISH} phmp_state_t;

    phmp_state_t state;
    logic [9:0] sync_a;
    logic [9:0] sync_b;
    logic [15:0] timer;
    logic [1:0] op;
    logic [1:0] byte_addr;
    logic [2:0] idx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0] int_status;
    logic [1:0] int_en;
    logic chip_sel_n;
    logic read_strobe_n;
    logic data_strobe_n;
    logic dir_read;
    logic [1:0] addr;
    logic [7:0] dout;
    logic oe;

    wire wr_acc = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
    wire start = wr_acc && PADDR_IN == HREG_CMD && state == H_IDLE;
    wire is_read = (op == OP_CTRL_READ) || (op == OP_WORD_READ);
    wire [1:0] tgt_addr = (op == OP_CTRL_READ) ? ADDR_CTRL :
                          (op == OP_BYTE_WRITE) ? byte_addr : ADDR_MSG;
    wire [2:0] nbytes = (op == OP_WORD_READ || op == OP_WORD_WRITE) ? WORD_BYTES : 3'h1;
    wire phase_end = (timer == 16'h0);
    wire done = (state == H_FINISH) && phase_end;

    // byte to drive for a given position
    function automatic logic [7:0] out_byte(input logic [1:0] o, input logic [31:0] w,
                                            input logic [2:0] i);
        if (o == OP_BYTE_WRITE) begin
            out_byte = w[7:0];
        end else begin
            unique case (i)
                3'h0: out_byte = w[31:24];
                3'h1: out_byte = w[23:16];
                3'h2: out_byte = w[15:8];
                default: out_byte = w[7:0];
            endcase
        end
    endfunction

    // synchroniser for device pins
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sync_a <= HOST_SYNC_RESET;
            sync_b <= HOST_SYNC_RESET;
        end else begin
            sync_a <= {PORT.message_irq_n, PORT.inbound_busy, PORT.port_data_bus};
            sync_b <= sync_a;
        end
    end

    // transfer sequencer driving the pins
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state <= H_IDLE;
            timer <= 16'h0;
            idx <= 3'h0;
            rdata <= 32'h0;
            chip_sel_n <= 1'b1;
            read_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            dir_read <= 1'b1;
            addr <= ADDR_MSG;
            dout <= 8'h00;
            oe <= 1'b0;
        end else if (state == H_IDLE) begin
            if (start) begin
                state <= H_SETUP;
                timer <= 16'(PHASE_CYCLES - 1);
                idx <= 3'h0;
                rdata <= 32'h0;
            end
        end else if (!phase_end) begin
            timer <= timer - 16'h1;
        end else begin
            timer <= 16'(PHASE_CYCLES - 1);
            unique case (state)
                H_SETUP: begin
                    // pins settle for a whole phase before chip select and strobe fall
                    if (addr == tgt_addr && dir_read == is_read && oe == !is_read) begin
                        state <= H_LOW;
                        chip_sel_n <= 1'b0;
                        read_strobe_n <= !is_read;
                        data_strobe_n <= is_read;
                    end else begin
                        addr <= tgt_addr;
                        dir_read <= is_read;
                        oe <= !is_read;
                        dout <= out_byte(op, wdata, 3'h0);
                    end
                end
                H_LOW: begin
                    state <= H_HIGH;
                    read_strobe_n <= 1'b1;
                    data_strobe_n <= 1'b1;
                    idx <= idx + 3'h1;
                    if (is_read) begin
                        rdata <= {rdata[23:0], sync_b[7:0]};
                    end
                end
                H_HIGH: begin
                    if (idx == nbytes) begin
                        state <= H_FINISH;
                        chip_sel_n <= 1'b1;
                    end else begin
                        state <= H_LOW;
                        read_strobe_n <= !is_read;
                        data_strobe_n <= is_read;
                        dout <= out_byte(op, wdata, idx);
                    end
                end
                default: begin
                    state <= H_IDLE;
                    oe <= 1'b0;
                    dir_read <= 1'b1;
                end
            endcase
        end
    end

    // apb register writes
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            op <= OP_CTRL_READ;
            byte_addr <= ADDR_CTRL;
            wdata <= 32'h0;
            int_en <= 2'h0;
        end else begin
            if (start) begin
                op <= PWDATA_IN[1:0];
                byte_addr <= PWDATA_IN[3:2];
            end
            if (wr_acc && PADDR_IN == HREG_WDATA && state == H_IDLE) begin
                wdata <= PWDATA_IN;
            end
            if (wr_acc && PADDR_IN == HREG_INT_ENABLE) begin
                int_en <= PWDATA_IN[1:0];
            end
        end
    end

    // sticky interrupt status, set wins over clear
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            int_status <= 2'h0;
            IRQ_OUT <= 1'b0;
        end else begin
            int_status[INT_DONE_BIT] <= done |
                (int_status[INT_DONE_BIT] & ~(wr_acc && PADDR_IN == HREG_INT_CLEAR &&
                 PWDATA_IN[INT_DONE_BIT]));
            int_status[INT_MSG_BIT] <= ~sync_b[9] |
                (int_status[INT_MSG_BIT] & ~(wr_acc && PADDR_IN == HREG_INT_CLEAR &&
                 PWDATA_IN[INT_MSG_BIT]));
            IRQ_OUT <= |(int_status & int_en);
        end
    end

    // apb answer one cycle after setup
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
        end else begin
            PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
            if (PSEL_IN && !PENABLE_IN) begin
                unique case (PADDR_IN)
                    HREG_CMD, HREG_WDATA: PRDATA_OUT <= 32'h0;
                    HREG_INT_CLEAR: PRDATA_OUT <= 32'h0;
                    HREG_RDATA: PRDATA_OUT <= rdata;
                    HREG_STATUS: PRDATA_OUT <= {29'h0, ~sync_b[9], sync_b[8], state != H_IDLE};
                    HREG_INT_STATUS: PRDATA_OUT <= {30'h0, int_status};
                    HREG_INT_ENABLE: PRDATA_OUT <= {30'h0, int_en};
                    default: PSLVERR_OUT <= 1'b1;
                endcase
            end
        end
    end

    // pins to the device
    assign PORT.chip_sel_n = chip_sel_n;
    assign PORT.read_strobe_n = read_strobe_n;
    assign PORT.data_strobe_n = data_strobe_n;
    assign PORT.dir_read = dir_read;
    assign PORT.reg_addr_hi = addr[1];
    assign PORT.reg_addr_lo = addr[0];
    assign PORT.host_data = dout;
    assign PORT.host_data_oe = oe;
endmodule

// file: rtl/phmp_pkg.sv
package phmp_pkg;
    // register addresses on the two address pins
    localparam logic [1:0] ADDR_MSG = 2'h0;
    localparam logic [1:0] ADDR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_BYTE_ONE = 2'h2;
    localparam logic [1:0] ADDR_BYTE_TWO = 2'h3;
    // control/status byte layout
    localparam int CTRL_OUT_READY_BIT = 1;
    localparam int CTRL_BUSY_BIT = 2;
    localparam logic [7:0] CTRL_HOST_MASK = 8'hf8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] LAST_BYTE = 3'h3;
    localparam logic [2:0] WORD_BYTES = 3'h4;
    // synchroniser reset images
    localparam logic [13:0] DEV_SYNC_RESET = 14'h3c00;
    localparam logic [9:0] HOST_SYNC_RESET = 10'h200;
    // host strobe phase timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int PHASE_NS = 64;
    localparam int PHASE_CYC = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host command codes
    localparam logic [1:0] OP_CTRL_READ = 2'h0;
    localparam logic [1:0] OP_WORD_READ = 2'h1;
    localparam logic [1:0] OP_BYTE_WRITE = 2'h2;
    localparam logic [1:0] OP_WORD_WRITE = 2'h3;
    // host apb register offsets
    localparam logic [7:0] HREG_CMD = 8'h00;
    localparam logic [7:0] HREG_WDATA = 8'h04;
    localparam logic [7:0] HREG_RDATA = 8'h08;
    localparam logic [7:0] HREG_STATUS = 8'h0c;
    localparam logic [7:0] HREG_INT_STATUS = 8'h10;
    localparam logic [7:0] HREG_INT_CLEAR = 8'h14;
    localparam logic [7:0] HREG_INT_ENABLE = 8'h18;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_MSG_BIT = 1;
endpackage

// file: rtl/phmp_if.sv
`timescale 1ns/1ns
interface phmp_if;
    logic chip_sel_n;
    logic read_strobe_n;
    logic data_strobe_n;
    logic dir_read;
    logic reg_addr_hi;
    logic reg_addr_lo;
    logic message_irq_n;
    logic inbound_busy;
    logic [7:0] host_data;
    logic host_data_oe;
    logic [7:0] dev_data;
    logic dev_data_oe;
    logic [7:0] port_data_bus;

    // resolved bus level, weak pull-up when nobody drives
    assign port_data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);

    modport device(
        input chip_sel_n, read_strobe_n, data_strobe_n, dir_read, reg_addr_hi, reg_addr_lo,
        input port_data_bus,
        output dev_data, dev_data_oe, message_irq_n, inbound_busy
    );
    modport host(
        output chip_sel_n, read_strobe_n, data_strobe_n, dir_read, reg_addr_hi, reg_addr_lo,
        output host_data, host_data_oe,
        input port_data_bus, message_irq_n, inbound_busy
    );
endinterface

// file: rtl/phmp_device.sv
// What this block does
// - four-byte reads only at message register
// - address latched at chip select fall
// - host releases data before read strobe
// - message read out most significant byte first
// - strobe rise acknowledges, next fall gives byte
// - host raises chip select after fourth byte
// - strobe-direction mode pin set
// - irq low while outbound message waits
// - irq also for unsolicited core messages
// - byte writes to control or data registers
// - direction low before strobes for write
// - byte captured into addressed register
// - four-byte writes assemble one message word
// - address held through whole word write
// - bytes latched on strobe rise, MSB first
// - chip select rise completes the word
// - busy bit two while word pending
`timescale 1ns/1ns
module phmp_device (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    // host port pins
    phmp_if.device PORT,
    // outbound messages from the core
    input wire logic OUT_MSG_VALID_IN,
    input wire logic [31:0] OUT_MSG_DATA_IN,
    output logic OUT_MSG_TAKEN_OUT,
    // inbound messages to the core
    output logic IN_MSG_VALID_OUT,
    output logic [31:0] IN_MSG_DATA_OUT,
    input wire logic IN_MSG_ACK_IN,
    // host written byte registers
    output logic [7:0] BYTE_ONE_OUT,
    output logic [7:0] BYTE_TWO_OUT,
    output logic [7:0] CTRL_OUT
);
    import phmp_pkg::*;

    logic [13:0] sync_a;
    logic [13:0] sync_b;
    logic cs_q;
    logic rs_q;
    logic ws_q;
    logic [1:0] addr_q;
    logic [2:0] cnt;
    logic [31:0] out_word;
    logic out_ready;
    logic next_out_ready;
    logic [31:0] in_shift;
    logic word_full;
    logic busy;
    logic irq_n;
    logic [7:0] dout;
    logic oe;

    // two-stage synchroniser for every pin from the host
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            sync_a <= DEV_SYNC_RESET;
            sync_b <= DEV_SYNC_RESET;
        end else begin
            sync_a <= {PORT.chip_sel_n, PORT.read_strobe_n, PORT.data_strobe_n, PORT.dir_read,
                       PORT.reg_addr_hi, PORT.reg_addr_lo, PORT.port_data_bus};
            sync_b <= sync_a;
        end
    end

    // strobe decode: separate read strobe or data strobe with direction
    wire cs_n_s = sync_b[13];
    wire rstrobe_n = sync_b[12] & (sync_b[11] | ~sync_b[10]);
    wire wstrobe_n = sync_b[11] | sync_b[10];
    wire [1:0] addr_s = sync_b[9:8];
    wire [7:0] data_s = sync_b[7:0];

    // edge detection on the synchronised strobes
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cs_q <= 1'b1;
            rs_q <= 1'b1;
            ws_q <= 1'b1;
        end else begin
            cs_q <= cs_n_s;
            rs_q <= rstrobe_n;
            ws_q <= wstrobe_n;
        end
    end

    wire cs_fall = cs_q & ~cs_n_s;
    wire cs_rise = ~cs_q & cs_n_s;
    wire rd_fall = rs_q & ~rstrobe_n & ~cs_n_s;
    wire rd_rise = ~rs_q & rstrobe_n & ~cs_n_s;
    wire wr_rise = ~ws_q & wstrobe_n & ~cs_n_s;
    wire [1:0] sel_addr = cs_fall ? addr_s : addr_q;
    wire sel_msg = (sel_addr == ADDR_MSG);

    // address latch at chip select fall
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            addr_q <= ADDR_MSG;
        end else if (cs_fall) begin
            addr_q <= addr_s;
        end
    end

    // byte position within a word transfer
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cnt <= 3'h0;
        end else if (cs_n_s) begin
            cnt <= 3'h0;
        end else if ((rd_rise || wr_rise) && sel_msg && cnt != WORD_BYTES) begin
            cnt <= cnt + 3'h1;
        end
    end

    // byte of the outbound word for a given position
    function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [2:0] idx);
        unique case (idx)
            3'h0: word_byte = w[31:24];
            3'h1: word_byte = w[23:16];
            3'h2: word_byte = w[15:8];
            default: word_byte = w[7:0];
        endcase
    endfunction

    // read data drive while the read strobe is low
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            dout <= 8'h00;
            oe <= 1'b0;
        end else if (rd_fall) begin
            oe <= 1'b1;
            unique case (sel_addr)
                ADDR_MSG: dout <= word_byte(out_word, cnt);
                ADDR_CTRL: dout <= {CTRL_OUT[7:3], busy, out_ready, 1'b0};
                default: dout <= 8'h00;
            endcase
        end else if (rstrobe_n || cs_n_s) begin
            oe <= 1'b0;
        end
    end

    // outbound message holding and ready flag
    always_comb begin
        next_out_ready = out_ready;
        if (rd_rise && sel_msg && cnt == LAST_BYTE) begin
            next_out_ready = 1'b0;
        end
        if (!out_ready && OUT_MSG_VALID_IN) begin
            next_out_ready = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            out_word <= 32'h0;
            out_ready <= 1'b0;
            irq_n <= 1'b1;
            OUT_MSG_TAKEN_OUT <= 1'b0;
        end else begin
            out_ready <= next_out_ready;
            irq_n <= ~next_out_ready;
            OUT_MSG_TAKEN_OUT <= !out_ready && OUT_MSG_VALID_IN;
            if (!out_ready && OUT_MSG_VALID_IN) begin
                out_word <= OUT_MSG_DATA_IN;
            end
        end
    end

    // host byte writes and word assembly
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            in_shift <= 32'h0;
            word_full <= 1'b0;
            BYTE_ONE_OUT <= 8'h00;
            BYTE_TWO_OUT <= 8'h00;
            CTRL_OUT <= CTRL_RESET;
        end else if (cs_n_s) begin
            word_full <= 1'b0;
        end else if (wr_rise) begin
            unique case (sel_addr)
                ADDR_MSG: begin
                    if (cnt != WORD_BYTES) begin
                        in_shift <= {in_shift[23:0], data_s};
                    end
                    if (cnt == LAST_BYTE) begin
                        word_full <= 1'b1;
                    end
                end
                ADDR_CTRL: CTRL_OUT <= data_s & CTRL_HOST_MASK;
                ADDR_BYTE_ONE: BYTE_ONE_OUT <= data_s;
                ADDR_BYTE_TWO: BYTE_TWO_OUT <= data_s;
            endcase
        end
    end

    // word delivery at chip select rise and busy flag
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            busy <= 1'b0;
            IN_MSG_VALID_OUT <= 1'b0;
            IN_MSG_DATA_OUT <= 32'h0;
        end else begin
            IN_MSG_VALID_OUT <= 1'b0;
            if (cs_rise && word_full && !busy) begin
                IN_MSG_VALID_OUT <= 1'b1;
                IN_MSG_DATA_OUT <= in_shift;
                busy <= 1'b1;
            end else if (IN_MSG_ACK_IN) begin
                busy <= 1'b0;
            end
        end
    end

    // pins back to the host
    assign PORT.dev_data = dout;
    assign PORT.dev_data_oe = oe;
    assign PORT.message_irq_n = irq_n;
    assign PORT.inbound_busy = busy;
endmodule

// file: verif/phmp_properties.sv
`timescale 1ns/1ns
module phmp_properties (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    // link pins driven by the host end
    input wire logic chip_sel_n,
    input wire logic read_strobe_n,
    input wire logic data_strobe_n,
    input wire logic dir_read,
    input wire logic reg_addr_hi,
    input wire logic reg_addr_lo,
    input wire logic host_data_oe,
    // link pins driven by the device end
    input wire logic message_irq_n,
    input wire logic inbound_busy,
    input wire logic dev_data_oe
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    logic rd_active;
    logic [3:0] rd_gap;

    // either form of read strobe counts as a read phase
    assign rd_active = !read_strobe_n || (!data_strobe_n && dir_read);

    // cycles since the last read phase, saturating so it never wraps
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rd_gap <= 4'hf;
        end else if (rd_active) begin
            rd_gap <= 4'h0;
        end else if (rd_gap != 4'hf) begin
            rd_gap <= rd_gap + 4'h1;
        end
    end

    property p_addr_stable;
        (!chip_sel_n && !$past(chip_sel_n)) |-> $stable({reg_addr_hi, reg_addr_lo});
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in frame");
    property p_no_contention;
        !(dev_data_oe && host_data_oe);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("both ends drive bus");
    property p_write_dir;
        (!chip_sel_n && host_data_oe) |-> !dir_read;
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("host drives data on read");
    property p_strobe_frame;
        (!data_strobe_n || !read_strobe_n) |-> !chip_sel_n;
    endproperty
    a_strobe_frame: assert property (p_strobe_frame) else $error("strobe outside frame");
    property p_read_answer;
        (rd_active && !chip_sel_n) [*7] |-> dev_data_oe;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no read byte driven");
    property p_dev_release;
        $fell(rd_active) |-> ##[1:6] !dev_data_oe;
    endproperty
    a_dev_release: assert property (p_dev_release) else $error("bus kept after strobe");
    property p_chip_idle;
        chip_sel_n [*6] |-> !dev_data_oe;
    endproperty
    a_chip_idle: assert property (p_chip_idle) else $error("device drives deselected");
    property p_busy_rise;
        $rose(inbound_busy) |-> chip_sel_n && $past(chip_sel_n, 2);
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy set inside frame");
    property p_irq_release;
        $rose(message_irq_n) |-> rd_gap < 4'ha;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq released unread");

    // main scenarios reached
    c_word_in: cover property ($rose(inbound_busy));
    c_irq: cover property ($fell(message_irq_n));
    c_read: cover property ($rose(dev_data_oe));
    c_irq_done: cover property ($rose(message_irq_n));
endmodule

// file: verif/parallel_host_message_port_tb.sv
`timescale 1ns/1ns
module parallel_host_message_port_tb;
    import phmp_pkg::*;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, byte_one, byte_two, ctrl_out;
    logic [31:0] pwdata, prdata, out_data, in_data, got_word;
    logic out_valid, out_taken, in_valid, in_ack;
    int n_errors = 0;
    int compares = 0;
    int n_words = 0;

    phmp_if link();
    phmp_device u_phmp_device (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .PORT(link),
        .OUT_MSG_VALID_IN(out_valid), .OUT_MSG_DATA_IN(out_data), .OUT_MSG_TAKEN_OUT(out_taken),
        .IN_MSG_VALID_OUT(in_valid), .IN_MSG_DATA_OUT(in_data), .IN_MSG_ACK_IN(in_ack),
        .BYTE_ONE_OUT(byte_one), .BYTE_TWO_OUT(byte_two), .CTRL_OUT(ctrl_out));
    phmp_host #(.PHASE_CYCLES(8)) u_phmp_host (.REF_CLK_IN(clk), .ARST_N_IN(arst_n),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .PORT(link));
    phmp_properties u_phmp_properties (.REF_CLK_IN(clk), .ARST_N_IN(arst_n),
        .chip_sel_n(link.chip_sel_n), .read_strobe_n(link.read_strobe_n),
        .data_strobe_n(link.data_strobe_n), .dir_read(link.dir_read),
        .reg_addr_hi(link.reg_addr_hi), .reg_addr_lo(link.reg_addr_lo),
        .host_data_oe(link.host_data_oe), .message_irq_n(link.message_irq_n),
        .inbound_busy(link.inbound_busy), .dev_data_oe(link.dev_data_oe));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // capture words handed to the core
    always @(posedge clk) begin
        if (in_valid === 1'b1) begin
            got_word <= in_data;
            n_words <= n_words + 1;
        end
    end

    // expected control byte as the host reads it back
    function automatic logic [31:0] f_ctrl(input logic [7:0] w, input logic busy, input logic rdy);
        return {24'h0, w[7:3], busy, rdy, 1'b0};
    endfunction

    function automatic logic [31:0] f_cmd(input logic [1:0] op, input logic [1:0] a);
        return {28'h0, a, op};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access until pready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    // issue a link command and poll until its done flag is set
    task automatic run_cmd(input logic [31:0] cmd);
        logic [31:0] v;
        wr(HREG_INT_CLEAR, 32'h1);
        wr(HREG_CMD, cmd);
        for (int k = 0; k < 200; k++) begin
            rd(HREG_INT_STATUS, v);
            if (v[INT_DONE_BIT] === 1'b1) break;
        end
        check("cmd done", 32'(v[INT_DONE_BIT]), 32'h1);
    endtask

    // the core offers a word until the device takes it
    task automatic offer(input logic [31:0] w);
        out_valid <= 1'b1;
        out_data <= w;
        do @(posedge clk); while (out_taken !== 1'b1);
        out_valid <= 1'b0;
    endtask

    // watchdog against hangs
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        logic [31:0] v, w, seed;
        logic e;
        logic [7:0] exp_b [4];
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {out_valid, out_data, in_ack, arst_n} = '0;
        seed = $urandom(59);
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check("irq pin", 32'(link.message_irq_n), 32'h1);
        check("busy pin", 32'(link.inbound_busy), 32'h0);
        apb(1'b0, 8'h40, 32'h0, v, e);
        check("unmapped error", 32'(e), 32'h1);
        // byte writes to control and both data registers
        for (int i = 1; i < 4; i++) begin
            exp_b[i] = 8'($urandom);
            wr(HREG_WDATA, {24'h0, exp_b[i]});
            run_cmd(f_cmd(OP_BYTE_WRITE, 2'(i)));
        end
        check("byte one", 32'(byte_one), 32'(exp_b[2]));
        check("byte two", 32'(byte_two), 32'(exp_b[3]));
        check("ctrl out", 32'(ctrl_out), 32'(exp_b[1] & CTRL_HOST_MASK));
        run_cmd(f_cmd(OP_CTRL_READ, ADDR_CTRL));
        rd(HREG_RDATA, v);
        check("ctrl idle", v, f_ctrl(exp_b[1], 1'b0, 1'b0));
        // inbound words, the first a boundary pattern, then its inverse refused while busy
        for (int j = 0; j < 3; j++) begin
            w = (j == 0) ? 32'h8000_0001 : $urandom;
            wr(HREG_WDATA, w);
            run_cmd(f_cmd(OP_WORD_WRITE, ADDR_MSG));
            for (int k = 0; k < 50 && n_words != j + 1; k++) @(posedge clk);
            check("word in", got_word, w);
            check("word count", 32'(n_words), 32'(j + 1));
            check("busy set", 32'(link.inbound_busy), 32'h1);
            if (j == 0) begin
                run_cmd(f_cmd(OP_CTRL_READ, ADDR_CTRL));
                rd(HREG_RDATA, v);
                check("ctrl busy", v, f_ctrl(exp_b[1], 1'b1, 1'b0));
                wr(HREG_WDATA, ~w);
                run_cmd(f_cmd(OP_WORD_WRITE, ADDR_MSG));
                repeat (10) @(posedge clk);
                check("refused count", 32'(n_words), 32'h1);
                check("refused word", got_word, w);
            end
            in_ack <= 1'b1;
            @(posedge clk);
            in_ack <= 1'b0;
            for (int k = 0; k < 10 && link.inbound_busy !== 1'b0; k++) @(posedge clk);
            check("busy clear", 32'(link.inbound_busy), 32'h0);
        end
        // unsolicited outbound words read back through the link
        for (int j = 0; j < 3; j++) begin
            w = $urandom;
            offer(w);
            @(posedge clk);
            check("irq low", 32'(link.message_irq_n), 32'h0);
            run_cmd(f_cmd(OP_CTRL_READ, ADDR_CTRL));
            rd(HREG_RDATA, v);
            check("ctrl ready", v, f_ctrl(exp_b[1], 1'b0, 1'b1));
            rd(HREG_STATUS, v);
            check("status irq", 32'(v[2]), 32'h1);
            rd(HREG_INT_STATUS, v);
            check("msg pending", 32'(v[INT_MSG_BIT]), 32'h1);
            check("irq masked", 32'(irq), {31'h0, j != 0});
            wr(HREG_INT_ENABLE, 32'h2);
            repeat (2) @(posedge clk);
            check("irq raised", 32'(irq), 32'h1);
            run_cmd(f_cmd(OP_WORD_READ, ADDR_MSG));
            rd(HREG_RDATA, v);
            check("word out", v, w);
            for (int k = 0; k < 20 && link.message_irq_n !== 1'b1; k++) @(posedge clk);
            check("irq released", 32'(link.message_irq_n), 32'h1);
            wr(HREG_INT_CLEAR, 32'h3);
            rd(HREG_INT_STATUS, v);
            check("int cleared", v & 32'h3, 32'h0);
            check("irq cleared", 32'(irq), 32'h0);
        end
        close_out();
    end
endmodule
